// ==== rtl/usm_baud.v ====
`timescale 1ns/100ps
`default_nettype none
// turns timer overflows into the 16x sample tick, counted in half ticks
module usm_baud (
   input wire clk,
   input wire nrst,
   input wire t1_ovf,
   input wire t2_ovf,
   input wire use_t2,
   input wire dbl,
   output reg tick16
);
   reg [2:0] acc_q;
   reg [2:0] acc_d;
   reg tick_d;
   reg [3:0] sum;
   reg [3:0] weight;
   reg ovf;

   always @* begin
      ovf = use_t2 ? t2_ovf : t1_ovf;
      weight = use_t2 ? (dbl ? 4'h4 : 4'h2) : (dbl ? 4'h2 : 4'h1);
      sum = {1'b0, acc_q} + (ovf ? weight : 4'h0);
      tick_d = 1'b0;
      if (sum >= 4'h2) begin
         tick_d = 1'b1;
         sum = sum - 4'h2;
      end
      acc_d = (sum > 4'h7) ? 3'h7 : sum[2:0];
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc_q <= 3'h0;
         tick16 <= 1'b0;
      end else begin
         acc_q <= acc_d;
         tick16 <= tick_d;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/usm_regs.vh ====
`ifndef USM_REGS_VH
`define USM_REGS_VH
// Function
// - global enable low blocks every interrupt request
// - serial enable in interrupt enable bit 4
// - serial priority in low priority bit 4
// - serial top priority in high priority bit 4
// - broadcast is own address OR mask
// - mode zero shifts on receive pin, clocks transmit
// - mode zero: eight bits LSB first, clock/12
// - mode zero write loads marker, active next clock
// - mode zero shifts right on falling clock
// - mode zero receive preloads 11111110 then activates
// - mode zero samples data on rising clock
// - preloaded zero at left ends mode zero receive
// - uart frame: start, eight data, stop
// - bit rate from timer overflow and doubling
// - transmit starts at next divide-by-16 rollover
// - start bit, data one bit later, shifts after
// - marker beside MSB ends transmit at rollover ten
// - falling edge resets counter, loads 1FF
// - majority of samples at states 7,8,9
// - non-zero start bit returns to hunting
// - start bit at left end triggers final check
// - flag clear and filter pass stores frame
// - start edge accepted only while receive allowed
// - given address is own address AND mask
// - filter needs valid stop and address match

// register byte offsets
`define USM_OFS_CTRL 8'h00
`define USM_OFS_BUF 8'h04
`define USM_OFS_IEN 8'h08
`define USM_OFS_PLO 8'h0C
`define USM_OFS_PHI 8'h10
`define USM_OFS_MASK 8'h14
`define USM_OFS_ADDR 8'h18
`define USM_OFS_BAUD 8'h1C

// port_control fields
`define USM_CTRL_MODE_HI 7
`define USM_CTRL_MODE_LO 6
`define USM_CTRL_FILT 5
`define USM_CTRL_RXEN 4
`define USM_CTRL_TX9 3
`define USM_CTRL_RX9 2
`define USM_CTRL_TDONE 1
`define USM_CTRL_RDONE 0

// other fields
`define USM_IEN_GLOBAL 7
`define USM_IEN_UART 4
`define USM_PLO_UART 4
`define USM_PHI_UART 4
`define USM_BAUD_DOUBLE 7
`define USM_BAUD_T2 0

`define USM_RST_BYTE 8'h00

`define USM_MODE_SHIFT 2'h0
`define USM_MODE_UART8 2'h1

// timing and preloads
`define USM_M0_DIV 4'hC
`define USM_M0_HALF 4'h6
`define USM_M0_PRELOAD 8'hFE
`define USM_RX_PRELOAD 9'h1FF
`define USM_CNT_LAST 4'hF
`define USM_SAMP_A 4'h7
`define USM_SAMP_B 4'h8
`define USM_SAMP_C 4'h9

`endif

// ==== rtl/usm_shift0.v ====
`timescale 1ns/100ps
`default_nettype none
`include "usm_regs.vh"
// synchronous shift-register mode engine
module usm_shift0 (
   input wire clk,
   input wire nrst,
   input wire en,
   input wire tx_load,
   input wire [7:0] tx_data,
   input wire rx_allow,
   input wire rxd_in,
   output wire tx_active,
   output wire rx_active,
   output wire sclk,
   output wire dout,
   output reg tx_done,
   output reg rx_done,
   output reg [7:0] rx_byte
);
   reg [3:0] ph_q;
   reg sclk_q;
   reg [8:0] txsh_q;
   reg txa_q;
   reg rxarm_q;
   reg rxa_q;
   reg [7:0] rxsh_q;
   wire [7:0] rx_next;
   wire [7:0] rx_rev;

   assign rx_next = {rxsh_q[6:0], rxd_in};
   // first bit in lands at the top, so reverse to keep LSB first
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_rev
         assign rx_rev[i] = rx_next[7 - i];
      end
   endgenerate

   assign tx_active = txa_q;
   assign rx_active = rxa_q;
   assign sclk = sclk_q;
   assign dout = txsh_q[0];

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ph_q <= 4'h0;
         sclk_q <= 1'b1;
         txsh_q <= 9'h000;
         txa_q <= 1'b0;
         rxarm_q <= 1'b0;
         rxa_q <= 1'b0;
         rxsh_q <= 8'h00;
         tx_done <= 1'b0;
         rx_done <= 1'b0;
         rx_byte <= 8'h00;
      end else begin
         tx_done <= 1'b0;
         rx_done <= 1'b0;
         if (!en) begin
            txa_q <= 1'b0;
            rxa_q <= 1'b0;
            rxarm_q <= 1'b0;
            sclk_q <= 1'b1;
            ph_q <= 4'h0;
         end else if (tx_load && !rxa_q && !rxarm_q) begin
            txsh_q <= {1'b1, tx_data};
            txa_q <= 1'b1;
            // open in the low half so the first rising edge already sees bit 0
            ph_q <= `USM_M0_HALF;
            sclk_q <= 1'b0;
         end else begin
            if (!txa_q && !rxa_q && !rxarm_q && !rx_done && rx_allow) begin
               rxsh_q <= `USM_M0_PRELOAD;
               rxarm_q <= 1'b1;
            end
            if (rxarm_q) begin
               rxarm_q <= 1'b0;
               rxa_q <= 1'b1;
               ph_q <= 4'h0;
            end
            if (!txa_q && !rxa_q) begin
               sclk_q <= 1'b1;
            end else begin
               ph_q <= (ph_q == `USM_M0_DIV - 4'h1) ? 4'h0 : ph_q + 4'h1;
               if (ph_q == `USM_M0_HALF - 4'h1) begin
                  sclk_q <= 1'b0;
                  if (txa_q) begin
                     txsh_q <= {1'b0, txsh_q[8:1]};
                     if (txsh_q[8:1] == 8'h01) begin
                        txa_q <= 1'b0;
                        tx_done <= 1'b1;
                     end
                  end
               end
               if (ph_q == `USM_M0_DIV - 4'h1) begin
                  sclk_q <= 1'b1;
                  if (rxa_q) begin
                     rxsh_q <= rx_next;
                     if (!rxsh_q[7]) begin
                        rxa_q <= 1'b0;
                        rx_done <= 1'b1;
                        rx_byte <= rx_rev;
                     end
                  end
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/usm_top.v ====
// Added by the designer: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "usm_regs.vh"
// serial port: shift-register mode and 8-bit uart mode, apb registers
module usm_top (
   input wire CLK,
   input wire NRST,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   input wire T1_OVF,
   input wire T2_OVF,
   input wire RXD_IN,
   output reg RXD_OUT,
   output reg RXD_OE,
   output reg TXD,
   output reg SER_IRQ,
   output reg SER_PRIO_LOW,
   output reg SER_PRIO_TOP
);
   // register state
   reg [7:0] ctrl_q;
   reg [7:0] ien_q;
   reg [7:0] plo_q;
   reg [7:0] phi_q;
   reg [7:0] mask_q;
   reg [7:0] addr_q;
   reg [7:0] baud_q;
   reg [7:0] rxbuf_q;
   reg tdone_q;
   reg rdone_q;
   reg rx9_q;

   // uart transmitter
   reg [3:0] tcnt_q;
   reg [8:0] tsh_q;
   reg treq_q;
   reg tsend_q;
   reg tdata_q;
   reg tfin_q;

   // uart receiver
   reg [3:0] rcnt_q;
   reg [8:0] rsh_q;
   reg rbusy_q;
   reg rfirst_q;
   reg rxd_prev_q;
   reg [1:0] samp_q;
   reg rfin_q;

   wire [1:0] mode;
   wire m0;
   wire m1;
   wire acc;
   wire wr;
   wire hit;
   wire buf_wr;
   wire tick16;
   wire t_roll;
   // outputs of the mode zero engine
   wire m0_txa;
   wire m0_rxa;
   wire m0_sclk;
   wire m0_dout;
   wire m0_tdone;
   wire m0_rdone;
   wire [7:0] m0_byte;
   wire bit_val;
   wire [7:0] given;
   wire [7:0] bcast;
   wire addr_ok;
   wire frame_ok;
   wire [7:0] r_byte;

   // mode 0 is the shift register, mode 1 the uart; other codes idle both engines
   assign mode = {ctrl_q[`USM_CTRL_MODE_HI], ctrl_q[`USM_CTRL_MODE_LO]};
   assign m0 = (mode == `USM_MODE_SHIFT);
   assign m1 = (mode == `USM_MODE_UART8);
   assign acc = PSEL && PENABLE;
   assign wr = acc && PWRITE;
   assign buf_wr = wr && (PADDR == `USM_OFS_BUF);
   assign hit = (PADDR == `USM_OFS_CTRL) || (PADDR == `USM_OFS_BUF) ||
                (PADDR == `USM_OFS_IEN) || (PADDR == `USM_OFS_PLO) ||
                (PADDR == `USM_OFS_PHI) || (PADDR == `USM_OFS_MASK) ||
                (PADDR == `USM_OFS_ADDR) || (PADDR == `USM_OFS_BAUD);
   // no wait states: every access completes in its first access cycle
   // an unmapped offset answers with an error, is not written and reads as zero
   assign PREADY = 1'b1;
   assign PSLVERR = acc && !hit;

   // sample tick at sixteen times the bit rate, from the chosen timer
   usm_baud u_baud (
      .clk(CLK),
      .nrst(NRST),
      .t1_ovf(T1_OVF),
      .t2_ovf(T2_OVF),
      .use_t2(baud_q[`USM_BAUD_T2]),
      .dbl(baud_q[`USM_BAUD_DOUBLE]),
      .tick16(tick16)
   );

   // mode zero engine; it ignores a buffer write while it receives
   usm_shift0 u_shift0 (
      .clk(CLK),
      .nrst(NRST),
      .en(m0),
      .tx_load(buf_wr),
      .tx_data(PWDATA[7:0]),
      .rx_allow(ctrl_q[`USM_CTRL_RXEN] && !rdone_q),
      .rxd_in(RXD_IN),
      .tx_active(m0_txa),
      .rx_active(m0_rxa),
      .sclk(m0_sclk),
      .dout(m0_dout),
      .tx_done(m0_tdone),
      .rx_done(m0_rdone),
      .rx_byte(m0_byte)
   );

   // address recognition
   assign given = addr_q & mask_q;
   assign bcast = addr_q | mask_q;
   // the first bit in ends at the top of the shifter; reverse so the byte is lsb first
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_rbyte
         assign r_byte[gi] = rsh_q[7 - gi];
      end
   endgenerate
   // zero mask bits are don't care; an all-zero broadcast accepts every byte
   assign addr_ok = (bcast == 8'h00) ||
                    (((r_byte ^ given) & mask_q) == 8'h00) ||
                    (((r_byte ^ bcast) & bcast) == 8'h00);
   // the third vote is the live line at state 9, so no extra flop is needed
   assign bit_val = (samp_q[0] & samp_q[1]) | (samp_q[0] & RXD_IN) |
                    (samp_q[1] & RXD_IN);
   assign frame_ok = !rdone_q && (!ctrl_q[`USM_CTRL_FILT] ||
                     (bit_val && addr_ok));
   // rollover of the free-running divide-by-16 counter paces every transmit bit
   assign t_roll = tick16 && (tcnt_q == `USM_CNT_LAST);

   // apb register writes and done flags; hardware set wins over clear
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ctrl_q <= `USM_RST_BYTE;
         ien_q <= `USM_RST_BYTE;
         plo_q <= `USM_RST_BYTE;
         phi_q <= `USM_RST_BYTE;
         mask_q <= `USM_RST_BYTE;
         addr_q <= `USM_RST_BYTE;
         baud_q <= `USM_RST_BYTE;
         tdone_q <= 1'b0;
         rdone_q <= 1'b0;
         PRDATA <= 32'h00000000;
      end else begin
         // writes land at the access edge; unmapped offsets fall to the default
         if (wr) begin
            case (PADDR)
               `USM_OFS_CTRL: ctrl_q <= PWDATA[7:0];
               `USM_OFS_IEN: ien_q <= PWDATA[7:0];
               `USM_OFS_PLO: plo_q <= PWDATA[7:0];
               `USM_OFS_PHI: phi_q <= PWDATA[7:0];
               `USM_OFS_MASK: mask_q <= PWDATA[7:0];
               `USM_OFS_ADDR: addr_q <= PWDATA[7:0];
               `USM_OFS_BAUD: baud_q <= PWDATA[7:0];
               default: ;
            endcase
         end
         // software loads both flags; a hardware set below wins in the same cycle
         if (wr && PADDR == `USM_OFS_CTRL) begin
            tdone_q <= PWDATA[`USM_CTRL_TDONE];
            rdone_q <= PWDATA[`USM_CTRL_RDONE];
         end
         if (m0_tdone || tfin_q) begin
            tdone_q <= 1'b1;
         end
         if (m0_rdone || rfin_q) begin
            rdone_q <= 1'b1;
         end
         // read data captured in the setup cycle
         if (PSEL && !PENABLE) begin
            case (PADDR)
               `USM_OFS_CTRL:
                  PRDATA <= {24'h000000, ctrl_q[7:3], rx9_q, tdone_q, rdone_q};
               `USM_OFS_BUF: PRDATA <= {24'h000000, rxbuf_q};
               `USM_OFS_IEN: PRDATA <= {24'h000000, ien_q};
               `USM_OFS_PLO: PRDATA <= {24'h000000, plo_q};
               `USM_OFS_PHI: PRDATA <= {24'h000000, phi_q};
               `USM_OFS_MASK: PRDATA <= {24'h000000, mask_q};
               `USM_OFS_ADDR: PRDATA <= {24'h000000, addr_q};
               `USM_OFS_BAUD: PRDATA <= {24'h000000, baud_q};
               default: PRDATA <= 32'h00000000;
            endcase
         end
      end
   end

   // uart transmitter, paced by its own divide-by-16 counter
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tcnt_q <= 4'h0;
         tsh_q <= 9'h000;
         treq_q <= 1'b0;
         tsend_q <= 1'b0;
         tdata_q <= 1'b0;
         tfin_q <= 1'b0;
      end else begin
         tfin_q <= 1'b0;
         // the counter runs free so bit times follow it, not the buffer write
         if (tick16) begin
            tcnt_q <= tcnt_q + 4'h1;
         end
         // leaving the uart mode abandons any frame in flight
         if (!m1) begin
            treq_q <= 1'b0;
            tsend_q <= 1'b0;
            tdata_q <= 1'b0;
         end else if (buf_wr) begin
            // the write only arms the request; the start bit waits for a rollover
            tsh_q <= {1'b1, PWDATA[7:0]};
            treq_q <= 1'b1;
         end else if (t_roll) begin
            if (treq_q && !tsend_q) begin
               treq_q <= 1'b0;
               tsend_q <= 1'b1;
               tdata_q <= 1'b0;
            end else if (tsend_q && !tdata_q) begin
               tdata_q <= 1'b1;
            end else if (tsend_q) begin
               tsh_q <= {1'b0, tsh_q[8:1]};
               // marker beside the msb: last shift, then the line idles high as stop
               if (tsh_q[8:1] == 8'h01) begin
                  tsend_q <= 1'b0;
                  tdata_q <= 1'b0;
                  tfin_q <= 1'b1;
               end
            end
         end
      end
   end

   // uart receiver
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rcnt_q <= 4'h0;
         rsh_q <= 9'h000;
         rbusy_q <= 1'b0;
         rfirst_q <= 1'b0;
         rxd_prev_q <= 1'b1;
         samp_q <= 2'h0;
         rfin_q <= 1'b0;
         rxbuf_q <= 8'h00;
         rx9_q <= 1'b0;
      end else begin
         rfin_q <= 1'b0;
         if (tick16) begin
            rxd_prev_q <= RXD_IN;
         end
         // both engines share the receive buffer
         if (m0_rdone) begin
            rxbuf_q <= m0_byte;
         end
         // leaving the uart mode drops a half-received frame
         if (!m1) begin
            rbusy_q <= 1'b0;
         end else if (!rbusy_q) begin
            // edges are seen only on sample ticks; shorter glitches may pass unseen
            if (tick16 && ctrl_q[`USM_CTRL_RXEN] && rxd_prev_q && !RXD_IN) begin
               rcnt_q <= 4'h0;
               rsh_q <= `USM_RX_PRELOAD;
               rbusy_q <= 1'b1;
               rfirst_q <= 1'b1;
            end
         end else if (tick16) begin
            rcnt_q <= rcnt_q + 4'h1;
            // samples at states 7, 8 and 9 feed the majority vote
            if (rcnt_q == `USM_SAMP_A) begin
               samp_q[0] <= RXD_IN;
            end
            if (rcnt_q == `USM_SAMP_B) begin
               samp_q[1] <= RXD_IN;
            end
            if (rcnt_q == `USM_SAMP_C) begin
               rfirst_q <= 1'b0;
               // a start bit that votes high was noise: back to hunting
               if (rfirst_q && bit_val) begin
                  rbusy_q <= 1'b0;
               end else if (!rsh_q[8] && !rfirst_q) begin
                  // stop bit sample: start bit sits at the left end
                  rbusy_q <= 1'b0;
                  // a refused frame is lost; hunting resumes either way
                  if (frame_ok) begin
                     rx9_q <= bit_val;
                     rxbuf_q <= r_byte;
                     rfin_q <= 1'b1;
                  end
               end else begin
                  rsh_q <= {rsh_q[7:0], bit_val};
               end
            end
         end
      end
   end

   // pins and interrupt request
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         TXD <= 1'b1;
         RXD_OUT <= 1'b1;
         RXD_OE <= 1'b0;
         SER_IRQ <= 1'b0;
         SER_PRIO_LOW <= 1'b0;
         SER_PRIO_TOP <= 1'b0;
      end else begin
         // mode zero: the transmit pin carries the clock, the receive pin the data
         if (m0) begin
            TXD <= (m0_txa || m0_rxa) ? m0_sclk : 1'b1;
            RXD_OUT <= m0_dout;
            RXD_OE <= m0_txa;
         end else begin
            // uart line: idle high, start bit low, then the shifter's output bit
            TXD <= !tsend_q ? 1'b1 : (tdata_q ? tsh_q[0] : 1'b0);
            RXD_OUT <= 1'b1;
            RXD_OE <= 1'b0;
         end
         // request stays up until software clears both done flags or clears the global or serial enable bit
         SER_IRQ <= ien_q[`USM_IEN_GLOBAL] && ien_q[`USM_IEN_UART] &&
                    (tdone_q || rdone_q);
         SER_PRIO_LOW <= plo_q[`USM_PLO_UART];
         SER_PRIO_TOP <= phi_q[`USM_PHI_UART];
      end
   end
endmodule
`default_nettype wire

// ==== verification/uart_shift_and_8bit_modes_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module uart_shift_and_8bit_modes_test;
   logic CLK, NRST, PSEL, PENABLE, PWRITE, T1_OVF, T2_OVF, pm0, serr;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rdat;
   logic PREADY, PSLVERR, RXD_IN, RXD_OUT, RXD_OE, TXD;
   logic SER_IRQ, SER_PRIO_LOW, SER_PRIO_TOP;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
   // byte, stop bit, expected control readback
   logic [19:0] fc [5] = '{20'h12170, 20'hC0070, 20'hC2175, 20'hFF175, 20'hFE174};
   usm_top dut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .T1_OVF(T1_OVF), .T2_OVF(T2_OVF), .RXD_IN(RXD_IN), .RXD_OUT(RXD_OUT),
      .RXD_OE(RXD_OE), .TXD(TXD), .SER_IRQ(SER_IRQ), .SER_PRIO_LOW(SER_PRIO_LOW),
      .SER_PRIO_TOP(SER_PRIO_TOP));
   usm_peer peer (.clk(CLK), .m0(pm0), .txd(TXD), .rxd_out(RXD_OUT), .rxd_oe(RXD_OE),
      .rxd_line(RXD_IN));
   always #2.5 CLK = ~CLK;
   always @(posedge CLK) begin
      T1_OVF <= ~T1_OVF;
      T2_OVF <= ~T2_OVF;
   end
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         conclude();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      rdat = PRDATA;
      serr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, a, {24'h0, d});
   endtask
   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(n, e, rdat);
   endtask
   task automatic wf(input int b);
      int n;
      n = 0;
      do begin
         acc(1'b0, 8'h00, 32'h0);
         n++;
      end while (rdat[b] !== 1'b1 && n < 800);
      chk("done flag", 32'h1, {31'h0, rdat[b]});
   endtask
   task automatic rx(input logic [7:0] b, input logic s);
      peer.send(b, s);
      repeat (4) @(posedge CLK);
   endtask
   initial begin
      CLK = 1'b0;
      NRST = 1'b0;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      T1_OVF = 1'b0;
      T2_OVF = 1'b0;
      pm0 = 1'b1;
      repeat (16) @(posedge CLK);
      NRST <= 1'b1;
      @(posedge CLK);
      foreach (ofs[i]) rc("reset value", ofs[i], 32'h0);
      acc(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, serr});
      for (int i = 2; i < 7; i++) begin
         wr(ofs[i], 8'hFF);
         rc("register", ofs[i], 32'hFF);
      end
      chk("prio low", 32'h1, {31'h0, SER_PRIO_LOW});
      chk("prio top", 32'h1, {31'h0, SER_PRIO_TOP});
      wr(8'h0C, 8'hEF);
      wr(8'h10, 8'hEF);
      @(posedge CLK);
      chk("prio low", 32'h0, {31'h0, SER_PRIO_LOW});
      chk("prio top", 32'h0, {31'h0, SER_PRIO_TOP});
      wr(8'h08, 8'h10);
      wr(8'h00, 8'h00);
      wr(8'h04, 8'hA6);
      wf(1);
      chk("shift tx", 32'hA6, {24'h0, peer.cap});
      chk("irq gated", 32'h0, {31'h0, SER_IRQ});
      wr(8'h08, 8'h90);
      repeat (2) @(posedge CLK);
      chk("irq", 32'h1, {31'h0, SER_IRQ});
      wr(8'h08, 8'h80);
      repeat (2) @(posedge CLK);
      chk("irq masked", 32'h0, {31'h0, SER_IRQ});
      wr(8'h08, 8'h90);
      peer.m0_load(8'h35);
      wr(8'h00, 8'h10);
      wf(0);
      rc("shift rx", 8'h04, 32'h35);
      wr(8'h00, 8'h00);
      repeat (2) @(posedge CLK);
      chk("irq cleared", 32'h0, {31'h0, SER_IRQ});
      pm0 <= 1'b0;
      wr(8'h1C, 8'h01);
      wr(8'h00, 8'h40);
      wr(8'h04, 8'h4B);
      wf(1);
      chk("uart tx", 32'h4B, {24'h0, peer.got});
      // the partner samples the stop bit half a bit after the done flag
      repeat (32) @(posedge CLK);
      chk("uart stop", 32'h1, {31'h0, peer.gstop});
      wr(8'h00, 8'h50);
      rx(8'hC5, 1'b1);
      rc("uart rx", 8'h04, 32'hC5);
      rc("ninth bit", 8'h00, 32'h55);
      rx(8'h11, 1'b1);
      rc("kept byte", 8'h04, 32'hC5);
      wr(8'h00, 8'h50);
      peer.glitch();
      repeat (40) @(posedge CLK);
      rx(8'h66, 1'b0);
      rc("after false start", 8'h04, 32'h66);
      rc("stop stored", 8'h00, 32'h51);
      wr(8'h14, 8'hFD);
      wr(8'h18, 8'hC0);
      foreach (fc[i]) begin
         wr(8'h00, 8'h70);
         rx(fc[i][19:12], fc[i][8]);
         rc("filter", 8'h00, {24'h0, fc[i][7:0]});
      end
      wr(8'h00, 8'h40);
      rx(8'h77, 1'b1);
      rc("receive off", 8'h00, 32'h44);
      conclude();
   end
endmodule
`default_nettype wire

// ==== verification/usm_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module usm_checker (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic TXD,
   input wire logic RXD_OUT,
   input wire logic RXD_OE,
   input wire logic SER_IRQ,
   input wire logic SER_PRIO_LOW,
   input wire logic SER_PRIO_TOP
);
   logic [7:0] ctl_q;
   logic [7:0] ien_q;
   logic [7:0] plo_q;
   logic [7:0] phi_q;
   wire logic wr_en = PSEL && PENABLE && PWRITE;
   wire logic wbuf = wr_en && PADDR == 8'h04;
   wire logic m0 = ctl_q[7:6] == 2'h0;
   wire logic m1 = ctl_q[7:6] == 2'h1;
   // mirror of the software-owned bits, taken from completed writes
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ctl_q <= 8'h00;
         ien_q <= 8'h00;
         plo_q <= 8'h00;
         phi_q <= 8'h00;
      end else if (wr_en) begin
         if (PADDR == 8'h00) ctl_q <= PWDATA[7:0];
         if (PADDR == 8'h08) ien_q <= PWDATA[7:0];
         if (PADDR == 8'h0C) plo_q <= PWDATA[7:0];
         if (PADDR == 8'h10) phi_q <= PWDATA[7:0];
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   a_irq_global: assert property (SER_IRQ |-> $past(ien_q[7]))
      else $error("serial request with global enable clear");
   a_irq_enable: assert property (SER_IRQ |-> $past(ien_q[4]))
      else $error("serial request with serial enable clear");
   a_prio_low: assert property (plo_q == $past(plo_q) && plo_q == $past(plo_q, 2)
      |-> SER_PRIO_LOW == plo_q[4])
      else $error("low priority output differs from bit 4");
   a_prio_top: assert property (phi_q == $past(phi_q) && phi_q == $past(phi_q, 2)
      |-> SER_PRIO_TOP == phi_q[4])
      else $error("top priority output differs from bit 4");
   a_oe_mode0: assert property (RXD_OE |-> m0 || $past(m0))
      else $error("data pin driven outside shift mode");
   a_m0_clk_low: assert property (m0 && $fell(TXD) |-> !TXD [*6] ##1 TXD)
      else $error("shift clock low phase not six cycles");
   a_m0_oe_start: assert property (wbuf && m0 && !ctl_q[4] && !RXD_OE |-> ##[1:3] RXD_OE)
      else $error("shift transmit did not start");
   a_m0_data_edge: assert property (m0 && RXD_OE && $past(RXD_OE) && $changed(RXD_OUT)
      |-> $fell(TXD))
      else $error("shift data changed off the falling clock");
   a_m1_start_late: assert property (wbuf && m1 && TXD |=> TXD)
      else $error("start bit launched at the buffer write");
endmodule
bind usm_top usm_checker chk (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .TXD(TXD), .RXD_OUT(RXD_OUT),
   .RXD_OE(RXD_OE), .SER_IRQ(SER_IRQ), .SER_PRIO_LOW(SER_PRIO_LOW),
   .SER_PRIO_TOP(SER_PRIO_TOP));
`default_nettype wire

// ==== verification/usm_peer.sv ====
`timescale 1ns/100ps
`default_nettype none
module usm_peer (
   input wire logic clk,
   input wire logic m0,
   input wire logic txd,
   input wire logic rxd_out,
   input wire logic rxd_oe,
   output logic rxd_line
);
   logic drv = 1'b1;
   logic tp = 1'b1;
   logic q = 1'b1;
   logic gstop;
   logic [7:0] sh = 8'hFF;
   logic [7:0] cap = 8'h00;
   logic [7:0] got = 8'h00;
   // the peripheral drives the data pin only while the device is not driving it
   assign rxd_line = rxd_oe ? rxd_out : (m0 ? sh[0] : drv);
   // next bit is presented just after the device sampled at the rising clock
   always @(posedge clk) begin
      tp <= txd;
      if (m0 && !rxd_oe && !tp && txd) begin
         sh <= {~sh[0], sh[7:1]};
      end
      if (m0 && rxd_oe && !tp && txd) begin
         cap <= {rxd_out, cap[7:1]};
      end
   end
   task automatic m0_load(input logic [7:0] b);
      sh <= b;
   endtask
   task automatic send(input logic [7:0] b, input logic s);
      drv <= 1'b0;
      repeat (32) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         drv <= b[i];
         repeat (32) @(posedge clk);
      end
      drv <= s;
      repeat (32) @(posedge clk);
      drv <= 1'b1;
   endtask
   task automatic glitch();
      drv <= 1'b0;
      repeat (6) @(posedge clk);
      drv <= 1'b1;
   endtask
   // frame receiver: mid-bit sampling, 32 clocks per bit
   initial forever begin
      @(posedge clk);
      if (!m0 && q && !txd) begin
         repeat (16) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (32) @(posedge clk);
            got[i] = txd;
         end
         repeat (32) @(posedge clk);
         gstop = txd;
      end
      q = txd;
   end
endmodule
`default_nettype wire
